// ---- rtl/cal_wd_pkg.sv ----
`default_nettype none
package cal_wd_pkg;
    // clock
    localparam int unsigned CLK_HZ            = 20_000_000;
    // strobe timing, width in ns, periods in microseconds (3.5 us pulse, 37/43/30 ms periods)
    localparam int unsigned STROBE_WIDTH_NS   = 3500;
    localparam int unsigned PERIOD_NORMAL_US  = 37000;
    localparam int unsigned PERIOD_LONG_US    = 43000;
    localparam int unsigned PERIOD_SHORT_US   = 30000;
    localparam int unsigned PERIOD_TOL_US     = 2500;
    localparam int unsigned SETPOINT_HOLD_S   = 140;
    // derived cycle counts
    localparam int unsigned STROBE_WIDTH_CYC  = (STROBE_WIDTH_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int unsigned PERIOD_NORMAL_CYC = PERIOD_NORMAL_US * (CLK_HZ / 1_000_000);
    localparam int unsigned PERIOD_LONG_CYC   = PERIOD_LONG_US * (CLK_HZ / 1_000_000);
    localparam int unsigned PERIOD_SHORT_CYC  = PERIOD_SHORT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned PERIOD_TOL_CYC    = PERIOD_TOL_US * (CLK_HZ / 1_000_000);
    localparam int unsigned SETPOINT_HOLD_CYC = SETPOINT_HOLD_S * CLK_HZ;
    // display codes (BCD digits; 0xA = dash, 0xB = blank)
    localparam logic [15:0] DISP_ZEROS        = 16'h0000;
    localparam logic [15:0] DISP_DASH2        = 16'hBA2A;
    localparam logic [15:0] DISP_DASH4        = 16'hBA4A;
    localparam logic [15:0] DISP_DASH5        = 16'hBA5A;
    localparam logic [15:0] DISP_DASH6        = 16'hBA6A;
    localparam logic [15:0] DISP_DASH7        = 16'hBA7A;
    localparam logic [15:0] DISP_247          = 16'hB247;
    localparam logic [15:0] DISP_37           = 16'hBB37;
    localparam logic [15:0] DISP_43           = 16'hBB43;
    localparam logic [15:0] DISP_30           = 16'hBB30;
    localparam logic [15:0] DISP_FAULT        = 16'hFFFF;
    // setpoints, mmHg
    localparam logic [8:0]  SETPOINT_LOW      = 9'd195;
    localparam logic [8:0]  SETPOINT_HIGH     = 9'd395;
    localparam logic [8:0]  SETPOINT_ZERO_CAL = 9'd247;
    // subroutine selection
    typedef enum logic [3:0] {
        SUB_IDLE   = 4'h0,
        SUB_ZINT   = 4'h1,
        SUB_ZEXT   = 4'h3,
        SUB_CMODE  = 4'h2,
        SUB_SPAN   = 4'h6,
        SUB_FACT   = 4'h7,
        SUB_NORMAL = 4'h5,
        SUB_LONG   = 4'h4,
        SUB_SHORT  = 4'hC,
        SUB_OFF    = 4'hD
    } sub_t;
endpackage
`default_nettype wire

// ---- rtl/calibration_mode_watchdog_test.sv ----
// Summary of operation
// - enter calibration when both decrease switches held
// - leave calibration only by power off
// - idle shows 0000 and -2-
// - common mode shows transducer sides
// - factory test alternates 195/395 every 140s
// - normal strobe 3.5us low every 37ms
// - strobe period within 2.5ms of nominal
// - long strobe 43ms shows 43, -6-
// - short strobe 30ms shows 30, -6-
// - strobe tests right after entry stay disarmed
// - transducer calibration arms the supervisor
// - armed normal strobe shows 37, -7-
// - armed off-period strobe trips, fault, -6-, tone
// - trip ignores alarm silence until power off
// - trip disables both valve drives
`timescale 1ns/1ps
`default_nettype none
module calibration_mode_watchdog_test (
    input  wire logic        i_clk,            // 20 MHz clock
    input  wire logic        i_rst_n,          // power switch reset, active low
    input  wire logic        i_sw_time_dec,    // time decrease switch
    input  wire logic        i_sw_time_inc,    // time increase switch
    input  wire logic        i_sw_press_dec,   // pressure decrease switch
    input  wire logic        i_sw_press_inc,   // pressure increase switch
    input  wire logic        i_sw_main_infl,   // main cuff inflate switch
    input  wire logic        i_sw_main_defl,   // main cuff deflate switch
    input  wire logic        i_sw_sec_infl,    // second cuff inflate switch
    input  wire logic        i_sw_sec_defl,    // second cuff deflate switch
    input  wire logic        i_alarm_silence,  // alarm silence button
    input  wire logic [15:0] i_sensed_disp,    // sensed pressure digits
    input  wire logic [15:0] i_xdcr_pos_disp,  // positive transducer side digits
    input  wire logic [15:0] i_xdcr_neg_disp,  // negative transducer side digits
    input  wire logic        i_valve_req_a,    // main valve request
    input  wire logic        i_valve_req_b,    // second valve request
    output logic             o_cal_mode,       // calibration mode active
    output logic [15:0]      o_press_disp,     // pressure display digits
    output logic [15:0]      o_time_disp,      // time display digits
    output logic [8:0]       o_setpoint,       // pressure setpoint, mmHg
    output logic             o_watchdog_strobe_n, // strobe_test_point, active low
    output logic             o_armed,          // watchdog_supervisor armed
    output logic             o_tripped,        // trip latched
    output logic             o_tone,           // high tone
    output logic             o_valve_a,        // main valve drive
    output logic             o_valve_b         // second valve drive
);
    typedef struct packed {
        logic                 started;
        logic                 cal;
        cal_wd_pkg::sub_t     sub;
        logic                 armed;
        logic                 tripped;
        logic                 had_strobe;
        logic [20:0]          strobe_cnt;   // period generator
        logic [20:0]          iv_cnt;       // supervisor interval counter
        logic [6:0]           pulse_cnt;
        logic                 strobe_n;
        logic [31:0]          fact_cnt;
        logic                 fact_high;
        logic [15:0]          press_disp;
        logic [15:0]          time_disp;
        logic [8:0]           setpoint;
        logic                 tone;
        logic                 valve_a;
        logic                 valve_b;
    } state_t;

    state_t s_reg;
    state_t s_next;

    // period of the strobe for the selected subroutine
    function automatic logic [20:0] period_of(input cal_wd_pkg::sub_t sub);
        case (sub)
            cal_wd_pkg::SUB_LONG:  period_of = 21'(cal_wd_pkg::PERIOD_LONG_CYC);
            cal_wd_pkg::SUB_SHORT: period_of = 21'(cal_wd_pkg::PERIOD_SHORT_CYC);
            default:               period_of = 21'(cal_wd_pkg::PERIOD_NORMAL_CYC);
        endcase
    endfunction

    // true in the three subroutines that run the strobe generator
    function automatic logic is_strobe(input cal_wd_pkg::sub_t sub);
        is_strobe = (sub == cal_wd_pkg::SUB_NORMAL) || (sub == cal_wd_pkg::SUB_LONG) ||
                    (sub == cal_wd_pkg::SUB_SHORT);
    endfunction

    logic        strobe_fall;
    logic [20:0] per;

    always_comb begin
        s_next      = s_reg;
        per         = period_of(s_reg.sub);
        strobe_fall = 1'b0;
        // entry is sampled once on the first clock after power-on
        if (!s_reg.started) begin
            s_next.started = 1'b1;
            s_next.cal     = i_sw_time_dec & i_sw_press_dec;
        end
        // only the power-switch reset clears cal; no input leaves it
        if (s_reg.cal && s_reg.started && !s_reg.tripped) begin
            if (i_sw_time_dec)       s_next.sub = cal_wd_pkg::SUB_ZINT;
            else if (i_sw_time_inc)  s_next.sub = cal_wd_pkg::SUB_ZEXT;
            else if (i_sw_press_dec) s_next.sub = cal_wd_pkg::SUB_CMODE;
            else if (i_sw_main_defl) s_next.sub = cal_wd_pkg::SUB_SPAN;
            else if (i_sw_main_infl) s_next.sub = cal_wd_pkg::SUB_FACT;
            else if (i_sw_press_inc) s_next.sub = cal_wd_pkg::SUB_NORMAL;
            else if (i_sw_sec_infl)  s_next.sub = cal_wd_pkg::SUB_LONG;
            else if (i_sw_sec_defl)  s_next.sub = cal_wd_pkg::SUB_SHORT;
        end
        // transducer calibrations arm for the rest of the session
        if (s_reg.sub == cal_wd_pkg::SUB_ZINT || s_reg.sub == cal_wd_pkg::SUB_ZEXT ||
            s_reg.sub == cal_wd_pkg::SUB_CMODE || s_reg.sub == cal_wd_pkg::SUB_SPAN) begin
            s_next.armed = 1'b1;
        end
        // strobe generator runs in all strobe subroutines
        if (is_strobe(s_reg.sub)) begin
            if (s_reg.strobe_cnt >= per - 21'd1) begin
                s_next.strobe_cnt = '0;
                s_next.strobe_n   = 1'b0;
                s_next.pulse_cnt  = 7'(cal_wd_pkg::STROBE_WIDTH_CYC);
                strobe_fall       = 1'b1;
            end else begin
                s_next.strobe_cnt = s_reg.strobe_cnt + 21'd1;
            end
        end else begin
            s_next.strobe_cnt = '0;
        end
        if (s_reg.pulse_cnt != 7'd0) begin
            s_next.pulse_cnt = s_reg.pulse_cnt - 7'd1;
            if (s_reg.pulse_cnt == 7'd1) s_next.strobe_n = 1'b1;
        end
        // supervisor: interval between strobes must sit in nominal window
        if (strobe_fall) begin
            s_next.iv_cnt     = '0;
            s_next.had_strobe = 1'b1;
            if (s_reg.armed && s_reg.had_strobe &&
                (s_reg.iv_cnt + 21'd1 < 21'(cal_wd_pkg::PERIOD_NORMAL_CYC
                                         - cal_wd_pkg::PERIOD_TOL_CYC))) begin
                s_next.tripped = 1'b1;
            end
        end else if (s_reg.had_strobe) begin
            if (s_reg.iv_cnt < 21'(cal_wd_pkg::PERIOD_NORMAL_CYC
                                   + cal_wd_pkg::PERIOD_TOL_CYC)) begin
                s_next.iv_cnt = s_reg.iv_cnt + 21'd1;
            end else if (s_reg.armed) begin
                s_next.tripped = 1'b1;
            end
        end
        // leaving strobe subroutines stops supervision to avoid false trips
        if (!is_strobe(s_next.sub) && !s_next.tripped) begin
            s_next.had_strobe = 1'b0;
        end
        // factory test alternating setpoint
        if (s_reg.sub == cal_wd_pkg::SUB_FACT) begin
            if (s_reg.fact_cnt >= cal_wd_pkg::SETPOINT_HOLD_CYC - 1) begin
                s_next.fact_cnt  = '0;
                s_next.fact_high = ~s_reg.fact_high;
            end else begin
                s_next.fact_cnt = s_reg.fact_cnt + 32'd1;
            end
            s_next.setpoint = s_reg.fact_high ? cal_wd_pkg::SETPOINT_HIGH
                                              : cal_wd_pkg::SETPOINT_LOW;
        end else if (s_reg.sub == cal_wd_pkg::SUB_ZINT) begin
            s_next.setpoint = cal_wd_pkg::SETPOINT_ZERO_CAL;
        end else begin
            s_next.fact_cnt = '0;
            s_next.setpoint = '0;
        end
        // displays
        case (s_reg.sub)
            cal_wd_pkg::SUB_IDLE: begin
                s_next.press_disp = cal_wd_pkg::DISP_ZEROS;
                s_next.time_disp  = cal_wd_pkg::DISP_DASH2;
            end
            cal_wd_pkg::SUB_ZINT: begin
                s_next.press_disp = i_sensed_disp;
                s_next.time_disp  = cal_wd_pkg::DISP_247;
            end
            cal_wd_pkg::SUB_ZEXT: begin
                s_next.press_disp = i_sensed_disp;
                s_next.time_disp  = cal_wd_pkg::DISP_DASH5;
            end
            cal_wd_pkg::SUB_CMODE: begin
                s_next.press_disp = i_xdcr_pos_disp;
                s_next.time_disp  = i_xdcr_neg_disp;
            end
            cal_wd_pkg::SUB_SPAN: begin
                s_next.press_disp = i_sensed_disp;
                s_next.time_disp  = cal_wd_pkg::DISP_DASH4;
            end
            cal_wd_pkg::SUB_FACT: begin
                s_next.press_disp = i_sensed_disp;
                s_next.time_disp  = {7'h00, s_next.setpoint};
            end
            cal_wd_pkg::SUB_NORMAL: begin
                s_next.press_disp = cal_wd_pkg::DISP_37;
                s_next.time_disp  = s_reg.armed ? cal_wd_pkg::DISP_DASH7
                                                : cal_wd_pkg::DISP_DASH6;
            end
            cal_wd_pkg::SUB_LONG: begin
                s_next.press_disp = cal_wd_pkg::DISP_43;
                s_next.time_disp  = cal_wd_pkg::DISP_DASH6;
            end
            cal_wd_pkg::SUB_SHORT: begin
                s_next.press_disp = cal_wd_pkg::DISP_30;
                s_next.time_disp  = cal_wd_pkg::DISP_DASH6;
            end
            default: begin
                s_next.press_disp = '0;
                s_next.time_disp  = '0;
            end
        endcase
        // an armed long/short selection trips on the spot, no period wait
        if (s_reg.armed && (s_reg.sub == cal_wd_pkg::SUB_LONG ||
                            s_reg.sub == cal_wd_pkg::SUB_SHORT)) begin
            s_next.tripped = 1'b1;
        end
        // valves follow requests unless tripped
        s_next.valve_a = i_valve_req_a & ~s_next.tripped;
        s_next.valve_b = i_valve_req_b & ~s_next.tripped;
        // trip is sticky; silence has no effect, only power off clears
        if (s_reg.tripped || s_next.tripped) begin
            s_next.press_disp = cal_wd_pkg::DISP_FAULT;
            s_next.time_disp  = cal_wd_pkg::DISP_DASH6;
            s_next.tone       = 1'b1;
        end else begin
            s_next.tone = 1'b0;
        end
        if (!s_reg.cal && s_reg.started) begin
            s_next = s_reg;
            s_next.valve_a = i_valve_req_a;
            s_next.valve_b = i_valve_req_b;
        end
    end

    // single state register; reset is the power switch
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_reg          <= '0;
            s_reg.strobe_n <= 1'b1;
            s_reg.time_disp <= cal_wd_pkg::DISP_DASH2;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_cal_mode          = s_reg.cal;
    assign o_press_disp        = s_reg.press_disp;
    assign o_time_disp         = s_reg.time_disp;
    assign o_setpoint          = s_reg.setpoint;
    assign o_watchdog_strobe_n = s_reg.strobe_n;
    assign o_armed             = s_reg.armed;
    assign o_tripped           = s_reg.tripped;
    assign o_tone              = s_reg.tone;
    assign o_valve_a           = s_reg.valve_a;
    assign o_valve_b           = s_reg.valve_b;
endmodule
`default_nettype wire

// ---- testbench/cal_wd_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// port-level checks on entry, arming, trip latch and valve gating
module cal_wd_props (
    input wire logic        i_clk,           // clock
    input wire logic        i_rst_n,         // power switch, active low
    input wire logic        i_sw_time_dec,   // entry key
    input wire logic        i_sw_press_dec,  // entry key
    input wire logic        i_alarm_silence, // silence button
    input wire logic        i_valve_req_a,   // valve request
    input wire logic        i_valve_req_b,   // valve request
    input wire logic        o_cal_mode,      // calibration mode
    input wire logic [15:0] o_press_disp,    // pressure digits
    input wire logic [15:0] o_time_disp,     // time digits
    input wire logic        o_armed,         // supervisor armed
    input wire logic        o_tripped,       // trip latched
    input wire logic        o_tone,          // high tone
    input wire logic        o_valve_a,       // valve drive
    input wire logic        o_valve_b        // valve drive
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // entry is decided by the keys at the first edge that sees power on
    cal_entry_a: assert property (
        i_rst_n && !$past(i_rst_n) |=> o_cal_mode == ($past(i_sw_time_dec) & $past(i_sw_press_dec)))
        else $error("calibration entry wrong");
    cal_hold_a: assert property (o_cal_mode |=> o_cal_mode)
        else $error("calibration mode left without power off");
    disarm_safe_a: assert property (!o_armed |-> !o_tripped)
        else $error("trip while disarmed");
    arm_hold_a: assert property (o_armed |=> o_armed)
        else $error("supervisor disarmed in session");
    trip_disp_a: assert property (
        o_tripped |-> o_press_disp == cal_wd_pkg::DISP_FAULT
            && o_time_disp == cal_wd_pkg::DISP_DASH6 && o_tone)
        else $error("trip indication wrong");
    tone_hold_a: assert property (o_tone && i_alarm_silence |=> o_tone)
        else $error("tone silenced");
    trip_latch_a: assert property (o_tripped |=> o_tripped)
        else $error("trip not latched");
    valve_off_a: assert property (o_tripped |-> !o_valve_a && !o_valve_b)
        else $error("valve driven after trip");
    // the first edge after reset still shows the reset value, so skip it
    valve_pass_a: assert property (
        $past(i_rst_n) && !o_tripped |-> o_valve_a == $past(i_valve_req_a)
            && o_valve_b == $past(i_valve_req_b))
        else $error("valve drive not following request");
endmodule
bind calibration_mode_watchdog_test cal_wd_props u_props (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sw_time_dec(i_sw_time_dec),
    .i_sw_press_dec(i_sw_press_dec), .i_alarm_silence(i_alarm_silence),
    .i_valve_req_a(i_valve_req_a), .i_valve_req_b(i_valve_req_b),
    .o_cal_mode(o_cal_mode), .o_press_disp(o_press_disp), .o_time_disp(o_time_disp),
    .o_armed(o_armed), .o_tripped(o_tripped), .o_tone(o_tone),
    .o_valve_a(o_valve_a), .o_valve_b(o_valve_b)
);
`default_nettype wire

// ---- testbench/panel_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// front panel keys: bit order time_dec, time_inc, press_dec, press_inc,
// main_infl, main_defl, sec_infl, sec_defl
module panel_model (
    input  wire logic       i_clk, // clock
    output var  logic [7:0] o_sw   // key levels
);
    initial o_sw = 8'h00;
    // a tap spans one sampling edge, so only one key is ever seen
    task automatic press(input int idx);
        @(posedge i_clk);
        o_sw <= 8'h01 << idx;
        @(posedge i_clk);
        o_sw <= 8'h00;
    endtask
    // a chord held through power-on
    task automatic hold(input logic [7:0] v);
        o_sw <= v;
    endtask
endmodule
`default_nettype wire

// ---- testbench/calibration_mode_watchdog_test_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module calibration_mode_watchdog_test_bench;
    logic        i_clk;
    logic        i_rst_n         = 1'b0;
    logic        i_alarm_silence = 1'b0;
    logic        i_valve_req_a   = 1'b0;
    logic        i_valve_req_b   = 1'b0;
    logic        strobe_n;
    logic [7:0]  sw;
    logic [15:0] sensed;
    logic [15:0] pos;
    logic [15:0] neg;
    logic        cal;
    logic [15:0] pdisp;
    logic [15:0] tdisp;
    logic [8:0]  setp;
    logic        armed;
    logic        tripped;
    logic        tone;
    logic        va;
    logic        vb;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          seed = 32'h8FBE6194;
    int          arm[4] = '{0, 1, 2, 5};
    int          dis[3] = '{3, 6, 7};

    panel_model u_panel (.i_clk(i_clk), .o_sw(sw));
    calibration_mode_watchdog_test u_calibration_mode_watchdog_test (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sw_time_dec(sw[0]), .i_sw_time_inc(sw[1]),
        .i_sw_press_dec(sw[2]), .i_sw_press_inc(sw[3]), .i_sw_main_infl(sw[4]),
        .i_sw_main_defl(sw[5]), .i_sw_sec_infl(sw[6]), .i_sw_sec_defl(sw[7]),
        .i_alarm_silence(i_alarm_silence), .i_sensed_disp(sensed),
        .i_xdcr_pos_disp(pos), .i_xdcr_neg_disp(neg), .i_valve_req_a(i_valve_req_a),
        .i_valve_req_b(i_valve_req_b), .o_cal_mode(cal), .o_press_disp(pdisp),
        .o_time_disp(tdisp), .o_setpoint(setp), .o_watchdog_strobe_n(strobe_n),
        .o_armed(armed), .o_tripped(tripped), .o_tone(tone), .o_valve_a(va), .o_valve_b(vb)
    );

    // 20 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // valve requests and the silence button wander at random all run long
    always @(posedge i_clk) begin
        i_valve_req_a   <= 1'($random(seed));
        i_valve_req_b   <= 1'($random(seed));
        i_alarm_silence <= 1'($random(seed));
    end

    function automatic logic [15:0] bcd();
        logic [15:0] v;
        for (int n = 0; n < 4; n++)
            v[n*4 +: 4] = 4'($unsigned($random(seed)) % 10);
        return v;
    endfunction

    // expected {pressure, time} digits for a selected key
    function automatic logic [31:0] exp_disp(input int idx, input logic arm_on);
        case (idx)
            0: return {sensed, cal_wd_pkg::DISP_247};
            1: return {sensed, cal_wd_pkg::DISP_DASH5};
            2: return {pos, neg};
            5: return {sensed, cal_wd_pkg::DISP_DASH4};
            3: return {cal_wd_pkg::DISP_37, arm_on ? cal_wd_pkg::DISP_DASH7 : cal_wd_pkg::DISP_DASH6};
            6: return {arm_on ? cal_wd_pkg::DISP_FAULT : cal_wd_pkg::DISP_43, cal_wd_pkg::DISP_DASH6};
            7: return {arm_on ? cal_wd_pkg::DISP_FAULT : cal_wd_pkg::DISP_30, cal_wd_pkg::DISP_DASH6};
            default: return {cal_wd_pkg::DISP_ZEROS, cal_wd_pkg::DISP_DASH2};
        endcase
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic check_disp(input int idx, input logic arm_on);
        logic [31:0] e;
        e = exp_disp(idx, arm_on);
        check(pdisp, e[31:16]);
        check(tdisp, e[15:0]);
    endtask

    // power cycle; the chord must be released right after the entry edge
    task automatic power(input logic entry);
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        u_panel.hold(entry ? 8'h05 : 8'h00);
        sensed <= bcd();
        pos <= bcd();
        neg <= bcd();
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        u_panel.hold(8'h00);
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
    endtask

    // displays settle two edges after the key, two spare edges kept
    task automatic sel(input int idx);
        u_panel.press(idx);
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge i_clk);
        error_cnt++;
        results();
    end

    initial begin
        power(1'b1);
        check(cal, 1'b1);
        check_disp(-1, 1'b0);
        foreach (dis[i]) begin
            sel(dis[i]);
            check_disp(dis[i], 1'b0);
            check(tripped, 1'b0);
        end
        // first strobe is a full period away, so the pin must still idle high
        check(strobe_n, 1'b1);
        for (int k = 0; k < 4; k++) begin
            power(1'b1);
            sel(arm[k]);
            check_disp(arm[k], 1'b0);
            check(armed, 1'b1);
            sel(3);
            check_disp(3, 1'b1);
            sel(6 + k % 2);
            check_disp(6, 1'b1);
            check(tone, 1'b1);
            check(va | vb, 1'b0);
            sel(k % 2);
            check(tone, 1'b1);
            check_disp(7, 1'b1);
            check(cal, 1'b1);
        end
        power(1'b1);
        sel(4);
        check(setp, cal_wd_pkg::SETPOINT_LOW);
        check(pdisp, sensed);
        power(1'b0);
        check(cal, 1'b0);
        sel(3);
        check_disp(-1, 1'b0);
        results();
    end
endmodule
`default_nettype wire
